// ==== design/acs_sequencer.sv ====
`timescale 1ns/1ps
// Overview of operation
// - divide select picks system clock divided 1..128
// - power enable low keeps converter powered off
// - reference code 01 uses analog supply, else pin
// - reference pin function disables other pin functions
// - analog pin drops original function and pull-high
// - analog pin overrides port direction setting
// - external sources route pins 0-7, else floating
// - source 001 bandgap, 010-100 ground
// - sample four clocks then convert twelve clocks
// - conversion runs in hardware without cpu help
// - start pulse low high low launches conversion
// - busy high during conversion, result valid after
// - twelve bit unsigned result, full scale fff
// - format bit aligns result in high/low pair
// - completion sets flag, interrupt when enabled
// - power off freezes result registers; power on then reloads them with a cleared result, 000
module acs_sequencer (
    input wire logic clock_i,               // system clock, 100 MHz
    input wire logic rst_b_i,               // synchronous reset, active low
    input wire logic [3:0] addr_i,          // register address
    input wire logic [7:0] wdata_i,         // register write data
    input wire logic wr_i,                  // write strobe
    input wire logic rd_i,                  // read strobe
    output logic [7:0] rdata_o,             // read data, cycle after strobe
    input wire logic comp_i,                // comparator: sample at or above trial level
    output logic [11:0] trial_o,            // trial code to the dac
    output logic power_o,                   // converter circuitry powered
    output logic sample_o,                  // sampling switch closed
    output logic ref_supply_o,              // reference from analog supply
    output logic ref_pin_o,                 // reference from reference pin
    output logic [7:0] chan_onehot_o,       // analog pin switch per channel
    output logic bandgap_sel_o,             // bandgap routed to converter
    output logic ground_sel_o,              // ground routed to converter
    output logic [7:0] pin_analog_o,        // pin in analog mode
    output logic [7:0] pullup_allow_o,      // pull-high allowed per pin
    output logic [7:0] dir_override_o,      // port direction overridden
    output logic ref_pin_other_off_o,       // reference pin other functions off
    output logic conv_irq_o                 // interrupt request to the cpu
);
    logic [7:0] ctrl_a_q;
    logic [7:0] ctrl_b_q;
    logic [7:0] pin_sel_q;
    logic ref_pin_fn_q;
    logic global_en_q;
    logic conv_en_q;
    logic conv_flag_q;
    logic busy_q;
    logic start_armed_q;
    logic [7:0] res_high_q;
    logic [7:0] res_low_q;
    logic [6:0] div_cnt_q;
    logic tick;
    logic [4:0] step_q;
    logic [11:0] sar_q;
    logic [11:0] result_q;
    logic done;
    logic launch;
    logic [7:0] rdata_q;
    acs_pkg::acs_state_type state_q;
    acs_pkg::acs_route_type route;

    // divide mask for a code: code n gives a period of 2**n clocks
    function automatic logic [6:0] div_mask(input logic [2:0] code);
        div_mask = 7'(({7'h00, 1'b1} << code) - 8'h01);
    endfunction

    // source and channel decode, used for the routing outputs
    function automatic acs_pkg::acs_route_type route_of(input logic [2:0] src,
                                                         input logic [3:0] ch);
        if (src == acs_pkg::SRC_BANDGAP) begin
            route_of = acs_pkg::ROUTE_BANDGAP;
        end else if (src >= acs_pkg::SRC_GND_LO && src <= acs_pkg::SRC_GND_HI) begin
            route_of = acs_pkg::ROUTE_GROUND;
        end else if (!ch[3]) begin
            route_of = acs_pkg::ROUTE_PIN;
        end else begin
            route_of = acs_pkg::ROUTE_NONE;
        end
    endfunction

    wire logic power_on = ctrl_a_q[acs_pkg::A_POWER_BIT];
    wire logic [2:0] src_sel = ctrl_b_q[acs_pkg::B_SRC_LSB +: 3];
    wire logic [1:0] ref_sel = ctrl_b_q[acs_pkg::B_REF_LSB +: 2];
    wire logic [2:0] div_sel = ctrl_b_q[acs_pkg::B_DIV_LSB +: 3];
    wire logic start_bit = ctrl_a_q[acs_pkg::A_START_BIT];
    wire logic ctrl_a_wr = wr_i && addr_i == acs_pkg::CTRL_A_ADDR;
    wire logic new_start = wdata_i[acs_pkg::A_START_BIT];

    // control registers; busy is read only so it is kept apart
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            ctrl_a_q <= acs_pkg::CTRL_RESET;
            ctrl_b_q <= acs_pkg::CTRL_RESET;
            pin_sel_q <= acs_pkg::CTRL_RESET;
            ref_pin_fn_q <= 1'b0;
            global_en_q <= 1'b0;
            conv_en_q <= 1'b0;
        end else if (wr_i) begin
            if (addr_i == acs_pkg::CTRL_A_ADDR) begin
                ctrl_a_q <= wdata_i;
            end else if (addr_i == acs_pkg::CTRL_B_ADDR) begin
                ctrl_b_q <= wdata_i;
            end else if (addr_i == acs_pkg::INT_CTRL_ADDR) begin
                global_en_q <= wdata_i[acs_pkg::I_GLOBAL_BIT];
                conv_en_q <= wdata_i[acs_pkg::I_CONV_EN_BIT];
            end else if (addr_i == acs_pkg::PIN_SEL_ADDR) begin
                pin_sel_q <= wdata_i;
            end else if (addr_i == acs_pkg::PIN_MISC_ADDR) begin
                ref_pin_fn_q <= wdata_i[0];
            end
        end
    end

    // start detection: a rise arms, the following fall launches
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            start_armed_q <= 1'b0;
        end else if (ctrl_a_wr && !start_bit && new_start) begin
            start_armed_q <= 1'b1;
        end else if (ctrl_a_wr && start_bit && !new_start) begin
            start_armed_q <= 1'b0;
        end
    end
    // holding start high never launches; only the falling write does
    // a relaunch while a run is in progress is ignored, so busy and timing hold
    assign launch = ctrl_a_wr && start_bit && !new_start && start_armed_q
                    && power_on && state_q == acs_pkg::ST_IDLE;

    // converter clock: divider runs while powered and restarts from zero at each launch
    always_ff @(posedge clock_i) begin
        if (!rst_b_i || !power_on || launch) begin
            div_cnt_q <= 7'h00;
        end else if (tick) begin
            div_cnt_q <= 7'h00;
        end else begin
            div_cnt_q <= 7'(div_cnt_q + 7'h01);
        end
    end
    // compare at or above so a smaller ratio written mid-count takes effect at once
    assign tick = div_cnt_q >= div_mask(div_sel);

    // sequence: sample then successive approximation, no cpu action needed
    always_ff @(posedge clock_i) begin
        if (!rst_b_i || !power_on) begin
            state_q <= acs_pkg::ST_IDLE;
            step_q <= 5'h00;
            sar_q <= 12'h000;
            result_q <= 12'h000;
        end else begin
            case (state_q)
                acs_pkg::ST_IDLE: begin
                    if (launch) begin
                        state_q <= acs_pkg::ST_SAMPLE;
                        step_q <= 5'h00;
                        sar_q <= 12'h800;
                    end
                end
                acs_pkg::ST_SAMPLE: begin
                    if (tick) begin
                        if (step_q == acs_pkg::SAMPLE_CLOCKS - 5'h01) begin
                            state_q <= acs_pkg::ST_CONVERT;
                        end
                        step_q <= 5'(step_q + 5'h01);
                    end
                end
                acs_pkg::ST_CONVERT: begin
                    if (tick) begin
                        // decide one bit per converter clock, msb first
                        sar_q <= (sar_q & ~(sar_q & -sar_q))
                                 | (comp_i ? (sar_q & -sar_q) : 12'h000)
                                 | ((sar_q & -sar_q) >> 1);
                        if (step_q == acs_pkg::TOTAL_CLOCKS - 5'h01) begin
                            state_q <= acs_pkg::ST_IDLE;
                            result_q <= comp_i ? sar_q : (sar_q & ~(sar_q & -sar_q));
                        end
                        step_q <= 5'(step_q + 5'h01);
                    end
                end
                default: begin
                    state_q <= acs_pkg::ST_IDLE;
                end
            endcase
        end
    end
    assign done = state_q == acs_pkg::ST_CONVERT && tick
                  && step_q == acs_pkg::TOTAL_CLOCKS - 5'h01;

    // busy flag: set on launch, cleared when the last bit is decided
    always_ff @(posedge clock_i) begin
        if (!rst_b_i || !power_on) begin
            busy_q <= 1'b0;
        end else if (launch) begin
            busy_q <= 1'b1;
        end else if (done) begin
            busy_q <= 1'b0;
        end
    end

    // result pair, aligned by format bit; frozen while powered off
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            res_high_q <= 8'h00;
            res_low_q <= 8'h00;
        end else if (power_on && state_q == acs_pkg::ST_IDLE && !busy_q) begin
            if (!ctrl_a_q[acs_pkg::A_ALIGN_BIT]) begin
                res_high_q <= result_q[11:4];
                res_low_q <= {result_q[3:0], 4'h0};
            end else begin
                res_high_q <= {4'h0, result_q[11:8]};
                res_low_q <= result_q[7:0];
            end
        end
    end

    // completion flag: the set beats a software clear in the same cycle
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            conv_flag_q <= 1'b0;
        end else if (done) begin
            conv_flag_q <= 1'b1;
        end else if (wr_i && addr_i == acs_pkg::INT_CTRL_ADDR) begin
            conv_flag_q <= wdata_i[acs_pkg::I_FLAG_BIT];
        end
    end
    assign conv_irq_o = conv_flag_q && conv_en_q && global_en_q;

    // read port, data stands the cycle after the strobe only
    always_ff @(posedge clock_i) begin
        if (!rst_b_i || !rd_i) begin
            rdata_q <= 8'h00;
        end else if (addr_i == acs_pkg::CTRL_A_ADDR) begin
            rdata_q <= {ctrl_a_q[7], busy_q, ctrl_a_q[5:0]};
        end else if (addr_i == acs_pkg::CTRL_B_ADDR) begin
            rdata_q <= ctrl_b_q;
        end else if (addr_i == acs_pkg::RES_HIGH_ADDR) begin
            rdata_q <= res_high_q;
        end else if (addr_i == acs_pkg::RES_LOW_ADDR) begin
            rdata_q <= res_low_q;
        end else if (addr_i == acs_pkg::INT_CTRL_ADDR) begin
            rdata_q <= {3'h0, conv_flag_q, 2'h0, conv_en_q, global_en_q};
        end else if (addr_i == acs_pkg::PIN_SEL_ADDR) begin
            rdata_q <= pin_sel_q;
        end else if (addr_i == acs_pkg::PIN_MISC_ADDR) begin
            rdata_q <= {7'h00, ref_pin_fn_q};
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign rdata_o = rdata_q;

    // analog routing; switches and reference selects are off while unpowered, the pin function outputs are not
    assign route = route_of(src_sel, ctrl_a_q[3:0]);
    assign power_o = power_on;
    assign sample_o = power_on && state_q == acs_pkg::ST_SAMPLE;
    assign trial_o = sar_q;
    assign ref_supply_o = power_on && ref_sel == acs_pkg::REF_SUPPLY;
    assign ref_pin_o = power_on && ref_sel != acs_pkg::REF_SUPPLY;
    assign bandgap_sel_o = power_on && route == acs_pkg::ROUTE_BANDGAP;
    assign ground_sel_o = power_on && route == acs_pkg::ROUTE_GROUND;
    // only a valid pin code with an external source closes a switch
    assign chan_onehot_o = (power_on && route == acs_pkg::ROUTE_PIN)
                           ? 8'(8'h01 << ctrl_a_q[2:0]) : 8'h00;
    assign pin_analog_o = pin_sel_q;
    assign pullup_allow_o = ~pin_sel_q;
    assign dir_override_o = pin_sel_q;
    assign ref_pin_other_off_o = ref_pin_fn_q;

    chk_busy_launch: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        launch |=> busy_q && state_q == acs_pkg::ST_SAMPLE)
        else $error("busy not raised on launch");
    chk_flag_done: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        done |=> conv_flag_q && !busy_q)
        else $error("flag not set at completion");
    chk_hold_start: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (state_q == acs_pkg::ST_IDLE && !(ctrl_a_wr && !new_start))
        |=> state_q == acs_pkg::ST_IDLE)
        else $error("launch without falling start");
    chk_sample_len: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (state_q == acs_pkg::ST_SAMPLE && tick
         && step_q == acs_pkg::SAMPLE_CLOCKS - 5'h01 && power_on)
        |=> state_q == acs_pkg::ST_CONVERT && step_q == acs_pkg::SAMPLE_CLOCKS)
        else $error("sampling length wrong");
    chk_div_one: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (power_on && div_sel == 3'h0) |-> tick)
        else $error("divide by one misses ticks");
    chk_power_off: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !power_on |-> chan_onehot_o == 8'h00 && !sample_o && !ref_pin_o)
        else $error("circuitry active while off");
    chk_res_frozen: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !power_on |=> $stable(res_high_q) && $stable(res_low_q))
        else $error("result changed while off");
    chk_ref_select: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        power_on |-> ref_supply_o != ref_pin_o)
        else $error("reference select broken");
    chk_float_code: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ctrl_a_q[3] |-> chan_onehot_o == 8'h00)
        else $error("missing channel code closed a switch");
    chk_irq_gate: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        conv_irq_o |-> conv_flag_q && conv_en_q && global_en_q)
        else $error("interrupt without enables");
endmodule

// ==== design/acs_pkg.sv ====
package acs_pkg;
    // register map of the plain register port (byte offsets)
    localparam logic [3:0] CTRL_A_ADDR = 4'h0;    // converter_control_a
    localparam logic [3:0] CTRL_B_ADDR = 4'h1;    // converter_control_b
    localparam logic [3:0] RES_HIGH_ADDR = 4'h2;  // result_high_register
    localparam logic [3:0] RES_LOW_ADDR = 4'h3;   // result_low_register
    localparam logic [3:0] INT_CTRL_ADDR = 4'h4;  // interrupt enables and flag
    localparam logic [3:0] PIN_SEL_ADDR = 4'h5;   // pin_function_select_regs
    localparam logic [3:0] PIN_MISC_ADDR = 4'h6;  // reference pin function bit
    // converter_control_a fields
    localparam int A_START_BIT = 7;
    localparam int A_BUSY_BIT = 6;
    localparam int A_POWER_BIT = 5;
    localparam int A_ALIGN_BIT = 4;
    // converter_control_b fields
    localparam int B_SRC_LSB = 5;
    localparam int B_REF_LSB = 3;
    localparam int B_DIV_LSB = 0;
    // interrupt control fields
    localparam int I_GLOBAL_BIT = 0;
    localparam int I_CONV_EN_BIT = 1;
    localparam int I_FLAG_BIT = 4;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // encodings
    localparam logic [1:0] REF_SUPPLY = 2'h1;
    localparam logic [2:0] SRC_BANDGAP = 3'h1;
    localparam logic [2:0] SRC_GND_LO = 3'h2;
    localparam logic [2:0] SRC_GND_HI = 3'h4;
    // conversion timing in converter clocks
    localparam logic [4:0] SAMPLE_CLOCKS = 5'h04;
    localparam logic [4:0] CONVERT_CLOCKS = 5'h0c;
    localparam logic [4:0] TOTAL_CLOCKS = 5'h10;
    localparam int DIV_WIDTH = 7;
    localparam logic [11:0] FULL_SCALE = 12'hfff;
    // analog routing selection
    typedef enum logic [3:0] {
        ROUTE_NONE = 4'b0001,
        ROUTE_PIN = 4'b0010,
        ROUTE_BANDGAP = 4'b0100,
        ROUTE_GROUND = 4'b1000
    } acs_route_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONVERT = 3'b100
    } acs_state_type;
endpackage

// ==== test/acs_analog_model.sv ====
`timescale 1ns/1ps
// far side of the converter: analog pins, bandgap and ground feeding the comparator
module acs_analog_model #(
    parameter logic [11:0] BG_LEVEL = 12'h5a3 // plain default level
) (
    input wire logic clock_i,             // system clock
    input wire logic [11:0] trial_i,      // trial code from the converter
    input wire logic [7:0] chan_onehot_i, // pin switches
    input wire logic bandgap_sel_i,       // bandgap routed
    input wire logic ground_sel_i,        // ground routed
    input wire logic [95:0] pin_levels_i, // twelve bits per pin
    output logic comp_o                   // input at or above trial
);
    logic wobble_q = 1'b0;
    logic [11:0] level;
    // a floating input has no level, so the answer flips every cycle
    always @(posedge clock_i) begin
        wobble_q <= ~wobble_q;
    end
    // pick the routed source; fff means input at the reference
    always_comb begin
        level = 12'h000;
        for (int i = 0; i < 8; i++) begin
            if (chan_onehot_i[i]) begin
                level = pin_levels_i[i*12 +: 12];
            end
        end
        if (bandgap_sel_i) begin
            level = BG_LEVEL;
        end
        if (ground_sel_i || bandgap_sel_i || chan_onehot_i != 8'h00) begin
            comp_o = (level >= trial_i);
        end else begin
            comp_o = wobble_q;
        end
    end
endmodule

// ==== test/acs_sequencer_tb_top.sv ====
`timescale 1ns/1ps
module acs_sequencer_tb_top;
    localparam logic [11:0] BG = 12'h5a3;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o, chan_onehot_o, pin_analog_o, pullup_allow_o, dir_override_o, rd_data, p;
    logic [11:0] trial_o, v, v_last;
    logic comp_i, power_o, sample_o, ref_supply_o, ref_pin_o, bandgap_sel_o, ground_sel_o;
    logic ref_pin_other_off_o, conv_irq_o, al, al_last;
    logic [95:0] pin_levels = '0;
    int fails = 0;
    int n_checks = 0;
    int c;

    acs_sequencer u_acs_sequencer (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .comp_i(comp_i),
        .trial_o(trial_o), .power_o(power_o), .sample_o(sample_o),
        .ref_supply_o(ref_supply_o), .ref_pin_o(ref_pin_o), .chan_onehot_o(chan_onehot_o),
        .bandgap_sel_o(bandgap_sel_o), .ground_sel_o(ground_sel_o),
        .pin_analog_o(pin_analog_o), .pullup_allow_o(pullup_allow_o),
        .dir_override_o(dir_override_o), .ref_pin_other_off_o(ref_pin_other_off_o),
        .conv_irq_o(conv_irq_o));
    acs_analog_model #(.BG_LEVEL(BG)) u_acs_analog_model (.clock_i(clock_i),
        .trial_i(trial_o), .chan_onehot_i(chan_onehot_o), .bandgap_sel_i(bandgap_sel_o),
        .ground_sel_i(ground_sel_o), .pin_levels_i(pin_levels), .comp_o(comp_i));

    always #5 clock_i = ~clock_i;

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // strobes stay up until the next call or idle, so no signal is set twice in a step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        @(posedge clock_i);
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        addr_i <= a;
        rd_i <= 1'b1;
        wr_i <= 1'b0;
        @(posedge clock_i);
        #1;
        rd_data = rdata_o;
    endtask
    task automatic idle(input int n);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    function automatic logic [15:0] fmt(input logic [11:0] x, input logic a);
        return a ? {4'h0, x} : {x, 4'h0};
    endfunction
    function automatic logic [7:0] exp_chan(input int s, input int ch);
        return ((s == 0 || s >= 5) && ch < 8) ? 8'h01 << ch : 8'h00;
    endfunction
    task automatic launch(input logic [7:0] low);
        wr(acs_pkg::CTRL_A_ADDR, 8'ha0 | low);
        wr(acs_pkg::CTRL_A_ADDR, 8'h20 | low);
    endtask
    // one full conversion with both enables set; phase lengths counted at the ports
    task automatic one_conv(input logic [7:0] cb, input logic [7:0] low, input logic [11:0] x);
        int ts;
        int tc;
        logic [7:0] h;
        ts = 0;
        tc = 0;
        wr(acs_pkg::CTRL_B_ADDR, cb);
        launch(low);
        wr_i <= 1'b0;
        for (int i = 0; i < 3000 && conv_irq_o !== 1'b1; i++) begin
            if (sample_o === 1'b1) ts++;
            else if (ts > 0) tc++;
            @(posedge clock_i);
            #1;
        end
        if (conv_irq_o !== 1'b1) begin
            check("conversion end", 16'h1, 16'h0);
            results();
        end
        check("sample clocks", 16'(4 << cb[2:0]), 16'(ts));
        check("convert clocks", 16'(12 << cb[2:0]), 16'(tc));
        idle(2);
        rd(acs_pkg::CTRL_A_ADDR);
        check("busy after end", 16'h0, {15'h0, rd_data[acs_pkg::A_BUSY_BIT]});
        rd(acs_pkg::RES_HIGH_ADDR);
        h = rd_data;
        rd(acs_pkg::RES_LOW_ADDR);
        check("result pair", fmt(x, low[4]), {h, rd_data});
        wr(acs_pkg::INT_CTRL_ADDR, 8'h03);
        idle(1);
        check("irq cleared", 16'h0, {15'h0, conv_irq_o});
    endtask

    initial begin
        void'($urandom(17));
        repeat (10) @(posedge clock_i);
        rst_b_i <= 1'b1;
        #1;
        check("pull-high at reset", 16'h00ff, {8'h0, pullup_allow_o});
        for (int a = 0; a < 16; a++) begin
            rd(4'(a));
            check("reset value", 16'h0, {8'h0, rd_data});
        end
        for (int i = 0; i < 4; i++) begin
            p = 8'($urandom);
            wr(acs_pkg::PIN_SEL_ADDR, p);
            idle(1);
            check("analog pins", {8'h0, p}, {8'h0, pin_analog_o});
            check("pull-high", {8'h0, ~p}, {8'h0, pullup_allow_o});
            check("dir override", {8'h0, p}, {8'h0, dir_override_o});
        end
        // start pulse with power off, then start held high with power on
        wr(acs_pkg::CTRL_A_ADDR, 8'h80);
        wr(acs_pkg::CTRL_A_ADDR, 8'h00);
        idle(3);
        check("sample unpowered", 16'h0, {15'h0, sample_o});
        wr(acs_pkg::CTRL_A_ADDR, 8'h20);
        idle(20);
        wr(acs_pkg::CTRL_A_ADDR, 8'ha0);
        idle(20);
        rd(acs_pkg::CTRL_A_ADDR);
        check("busy start held", 16'h0, {15'h0, rd_data[acs_pkg::A_BUSY_BIT]});
        wr(acs_pkg::CTRL_A_ADDR, 8'h00);
        wr(acs_pkg::CTRL_A_ADDR, 8'h20);
        for (int r = 0; r < 4; r++) begin
            wr(acs_pkg::PIN_MISC_ADDR, (r == 1) ? 8'h00 : 8'h01);
            wr(acs_pkg::CTRL_B_ADDR, 8'(r << 3));
            idle(1);
            check("ref supply", 16'(r == 1), {15'h0, ref_supply_o});
            check("ref pin", 16'(r != 1), {15'h0, ref_pin_o});
            check("ref pin others off", 16'(r != 1), {15'h0, ref_pin_other_off_o});
        end
        for (int s = 0; s < 8; s++) begin
            for (int ch = 0; ch < 16; ch++) begin
                wr(acs_pkg::CTRL_B_ADDR, 8'(s << 5));
                wr(acs_pkg::CTRL_A_ADDR, 8'h20 | 8'(ch));
                idle(1);
                check("pin switch", {8'h0, exp_chan(s, ch)}, {8'h0, chan_onehot_o});
                check("internal route", 16'({s == 1, s >= 2 && s <= 4}),
                    {14'h0, bandgap_sel_o, ground_sel_o});
            end
        end
        wr(acs_pkg::INT_CTRL_ADDR, 8'h03);
        for (int k = 0; k < 8; k++) begin
            c = (k == 1) ? 7 : $urandom_range(7);
            v = (k == 0) ? 12'h000 : (k == 1) ? 12'hfff : 12'($urandom);
            al = (k == 1) ? 1'b1 : 1'($urandom);
            pin_levels[c*12 +: 12] <= v;
            wr(acs_pkg::PIN_SEL_ADDR, 8'h01 << c);
            one_conv({3'((k >= 5) ? k : 0), 2'h0, 3'(k)}, {3'h0, al, 4'(c)}, v);
            v_last = v;
            al_last = al;
        end
        // power dropped mid-run: run stops and results stay frozen
        launch({3'h0, al_last, 4'h0});
        rd(acs_pkg::CTRL_A_ADDR);
        check("busy in run", 16'h1, {15'h0, rd_data[acs_pkg::A_BUSY_BIT]});
        wr(acs_pkg::CTRL_A_ADDR, {3'h0, al_last, 4'h0});
        idle(40);
        check("sample off", 16'h0, {15'h0, sample_o});
        rd(acs_pkg::RES_HIGH_ADDR);
        check("frozen high", 16'(fmt(v_last, al_last) >> 8), {8'h0, rd_data});
        // converter enable alone: flag rises but no request until global enable
        wr(acs_pkg::INT_CTRL_ADDR, 8'h02);
        wr(acs_pkg::CTRL_B_ADDR, 8'h00);
        wr(acs_pkg::CTRL_A_ADDR, 8'h20);
        idle(20);
        launch(8'h00);
        idle(25);
        rd(acs_pkg::INT_CTRL_ADDR);
        check("flag set", 16'h1, {15'h0, rd_data[acs_pkg::I_FLAG_BIT]});
        check("irq masked", 16'h0, {15'h0, conv_irq_o});
        wr(acs_pkg::INT_CTRL_ADDR, 8'h13);
        idle(1);
        check("irq unmasked", 16'h1, {15'h0, conv_irq_o});
        wr(acs_pkg::INT_CTRL_ADDR, 8'h03);
        wr(acs_pkg::CTRL_A_ADDR, 8'h28);
        for (int s = 1; s < 5; s++) begin
            one_conv(8'(s << 5), 8'h08, (s == 1) ? BG : 12'h000);
        end
        results();
    end
endmodule
